// >>> bench/host_model.sv
// host side model driving the enable and alive pins
`timescale 1ns/10ps
module host_model (
    input wire logic ref_clk,
    input wire logic en_req,
    input wire logic alive_req,
    input wire logic [2:0] pins_req,
    output logic chip_en,
    output logic host_alive_pin,
    output logic [2:0] buck_en_pin
);
    // pins follow host requests one edge later
    always_ff @(posedge ref_clk) begin
        chip_en <= en_req;
        host_alive_pin <= alive_req;
        buck_en_pin <= pins_req;
    end
endmodule : host_model

// >>> bench/testbench.sv
// self-checking bench of the buck sequencer
`timescale 1ns/10ps
module testbench;
    logic ref_clk, sys_rst, en_req, alive_req, reg_wr, reg_rd, chip_en;
    logic host_alive_pin, bias_on, irq_out, irq_oe;
    logic [2:0] pins_req, buck_en_pin;
    logic [3:0] reg_addr, buck_run, stage_hiz, low_side_on, weak_pd_on;
    logic [31:0] reg_wdata, reg_rdata, seed, rv;
    logic [39:0] vout_code;
    logic [1:0] ovuv_window;
    logic ot_fault;
    logic [3:0] oc_fault, ov_fault, uv_fault;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    host_model partner (.ref_clk, .en_req, .alive_req, .pins_req, .chip_en,
        .host_alive_pin, .buck_en_pin);
    buck_sequencer #(.BOOT_CYC(20), .WDOG_CYC(30)) dut (.ref_clk, .sys_rst,
        .chip_en, .host_alive_pin, .buck_en_pin, .ot_fault, .oc_fault,
        .ov_fault, .uv_fault, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bias_on, .buck_run,
        .stage_hiz, .low_side_on, .weak_pd_on, .vout_code, .ovuv_window,
        .irq_out, .irq_oe);
    function automatic logic [31:0] dflt(input logic [31:0] c);
        return 32'(c[27:18]);
    endfunction : dflt
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, e);
    endtask : rd
    task automatic chk_tgt();
        for (int k = 0; k < 4; k++) begin
            rd(seq_pkg::REG_VTGT0 + 4'(k), dflt(seq_pkg::OTP_CFG_DEF));
        end
    endtask : chk_tgt
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    // boot, manual, pin, watchdog, irq and shutdown runs
    initial begin
        {sys_rst, alive_req, seed} = {2'h3, 32'h86fb_5c1c};
        {en_req, pins_req, reg_wr, reg_rd, reg_addr} = 10'h000;
        reg_wdata = 32'h0000_0000;
        {ot_fault, oc_fault, ov_fault, uv_fault} = 13'h0000;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(4'h4, 32'h0000_0000);
        @(posedge ref_clk) en_req <= 1'b1;
        repeat (40) @(posedge ref_clk);
        rd(seq_pkg::REG_CTRL, seq_pkg::OTP_CTRL_DEF);
        chk_tgt();
        rd(seq_pkg::REG_STATE, 32'h0000_0030);
        wr(seq_pkg::REG_CTRL, 32'h0000_2101);
        repeat (5) @(negedge ref_clk);
        check(32'({ovuv_window, buck_run}), 32'h0000_0021);
        wr(seq_pkg::REG_CTRL, 32'h0000_0100);
        repeat (30) @(negedge ref_clk);
        check(32'({buck_run, weak_pd_on}), 32'h0000_0001);
        rv = $random(seed);
        wr(seq_pkg::REG_CTRL, 32'h0000_001f);
        @(posedge ref_clk) pins_req <= rv[2:0];
        repeat (5) @(negedge ref_clk);
        check(32'(buck_run), 32'({1'b1, rv[2:0]}));
        wr(seq_pkg::REG_CTRL, 32'h0000_0000);
        @(posedge ref_clk) pins_req <= 3'h0;
        repeat (30) @(negedge ref_clk);
        check(32'(buck_run), 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(seq_pkg::REG_VTGT0 + 4'(k), $random(seed) & 32'h0000_03ff);
        end
        @(posedge ref_clk) alive_req <= 1'b0;
        repeat (40) @(posedge ref_clk);
        alive_req <= 1'b1;
        chk_tgt();
        rd(seq_pkg::REG_STATUS, 32'h0000_2000);
        rv = $random(seed) & 32'h0000_3fff;
        wr(seq_pkg::REG_MASK, rv);
        rd(seq_pkg::REG_MASK, rv);
        rd(4'hc, 32'h0000_0000);
        wr(seq_pkg::REG_MASK, 32'h0000_2000);
        for (int k = 0; k < 4; k++) begin
            wr(seq_pkg::REG_CTRL, 32'(k) << 14);
            repeat (3) @(negedge ref_clk);
            check(32'({irq_out, irq_oe}), k[1] ? 32'(!k[0]) : 32'(2 * k + 1));
        end
        // chip disable with buck0 on and no stop delay: controlled ramp-down, no pull-down
        wr(seq_pkg::REG_CFG0, seq_pkg::OTP_CFG_DEF & 32'hffff_f03f);
        wr(seq_pkg::REG_CTRL, 32'h0000_0101);
        @(posedge ref_clk) en_req <= 1'b0;
        repeat (20) @(negedge ref_clk);
        check(32'({bias_on, weak_pd_on}), 32'h0000_0000);
        // reboot, manual start, one overvoltage pulse on buck0
        @(posedge ref_clk) en_req <= 1'b1;
        repeat (40) @(posedge ref_clk);
        wr(seq_pkg::REG_CTRL, 32'h0000_0001);
        @(posedge ref_clk) ov_fault <= 4'h1;
        @(posedge ref_clk) ov_fault <= 4'h0;
        repeat (5) @(negedge ref_clk);
        check(32'({low_side_on, stage_hiz}), 32'h0000_0010);
        repeat (1600) @(negedge ref_clk);
        check(32'({low_side_on, stage_hiz}), 32'h0000_0001);
        @(posedge ref_clk) en_req <= 1'b0;
        repeat (20) @(negedge ref_clk);
        check(32'(bias_on), 32'h0000_0000);
        end_sim();
    end
endmodule : testbench

// >>> core/buck_sequencer.sv
// sequencing, watchdog, fault and interrupt control of four bucks
// Function
// - chip enable boots, loads memory, picks path
// - manual start by turn-on bit, gated by pins for bucks 0..2 if selected
// - soft-start uses ramp-up slew field
// - start delay ignored in manual start
// - auto start after boot and delays
// - manual disable ramps only that buck down
// - stop delay ignored in manual power-down
// - chip enable low: delayed ramp, then shutdown
// - ramp-down slew field, controlled to floor
// - no weak pull-down after chip disable
// - weak pull-down after manual disable if selected
// - host-alive low 10ms restores default voltages
// - host-alive active low, acts on all bucks
// - boot loads voltage targets from memory
// - recovery is debounce plus slew time
// - masked interrupt, polarity and drive selectable
// - over-temperature stops all until cleared
// - overcurrent: off, high-z, periodic retry
// - overvoltage: crowbar, off, retry
// - undervoltage: off and restart repeatedly
// - configurable over/undervoltage window
`timescale 1ns/10ps
module buck_sequencer #(
    parameter int BOOT_CYC = seq_pkg::BOOT_CYC,
    parameter int WDOG_CYC = seq_pkg::WDOG_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic chip_en,
    input wire logic host_alive_pin,
    input wire logic [2:0] buck_en_pin,
    input wire logic ot_fault,
    input wire logic [3:0] oc_fault,
    input wire logic [3:0] ov_fault,
    input wire logic [3:0] uv_fault,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic bias_on,
    output logic [3:0] buck_run,
    output logic [3:0] stage_hiz,
    output logic [3:0] low_side_on,
    output logic [3:0] weak_pd_on,
    output logic [39:0] vout_code,
    output logic [1:0] ovuv_window,
    output logic irq_out,
    output logic irq_oe
);
    // -----------------------------------------------------------------
    // state and storage
    // -----------------------------------------------------------------
    seq_pkg::chip_st_t gst_q;
    seq_pkg::buck_st_t st_q [4];
    logic [31:0] ctrl_q, mask_q;
    logic [31:0] cfg_q [4];
    logic [9:0] vtgt_q [4], vo_q [4];
    logic [10:0] cnt_q [4];
    logic [2:0] slc_q [4];
    logic [3:0] pd_q, first_q, cause_q;
    logic [seq_pkg::ST_W-1:0] status_q;
    logic [16:0] boot_cnt_q;
    logic [18:0] wd_cnt_q;
    logic [5:0] us_cnt_q;
    logic [9:0] ms_cnt_q;
    logic us_tick_q, ms_tick_q;
    logic [2:0] ld_a_q;
    logic ld_vld_q, ld_done_q;
    otp_if otp ();

    function automatic logic [5:0] fld6(input logic [31:0] w, input int l);
        fld6 = w[l +: 6];
    endfunction : fld6

    function automatic logic [2:0] fld3(input logic [31:0] w, input int l);
        fld3 = w[l +: 3];
    endfunction : fld3

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    wire logic [3:0] turn_on = ctrl_q[seq_pkg::CTRL_ON_LSB +: 4];
    wire logic [2:0] pin_fn = ctrl_q[seq_pkg::CTRL_PIN_LSB +: 3];
    wire logic auto_mode = ctrl_q[seq_pkg::CTRL_AUTO_BIT];
    wire logic [3:0] dis_sel = ctrl_q[seq_pkg::CTRL_DIS_LSB +: 4];
    wire logic pins_on = (pin_fn == seq_pkg::PIN_FN_EN);
    wire logic running = (gst_q == seq_pkg::G_RUN);
    wire logic stopping = (gst_q == seq_pkg::G_STOP);
    wire logic [3:0] pin_ok = {1'b1, buck_en_pin | {3{~pins_on}}};
    wire logic [3:0] want = {4{running}} & turn_on & pin_ok;
    wire logic boot_done = ld_done_q && (boot_cnt_q == 17'h0_0000);
    wire logic wd_low = ~host_alive_pin & running;
    wire logic wd_fire = wd_low && (wd_cnt_q == 19'(WDOG_CYC - 1));
    wire logic [3:0] is_off;
    wire logic [3:0] step;
    wire logic wr_status = reg_wr && (reg_addr == seq_pkg::REG_STATUS);
    wire logic [seq_pkg::ST_W-1:0] st_clr = wr_status ?
        reg_wdata[seq_pkg::ST_W-1:0] : '0;
    wire logic [seq_pkg::ST_W-1:0] st_ev = {wd_fire, ot_fault, uv_fault,
        ov_fault, oc_fault};
    wire logic irq_act = |(status_q & mask_q[seq_pkg::ST_W-1:0]);
    wire logic irq_lvl = irq_act ~^ ctrl_q[seq_pkg::CTRL_POL_BIT];
    wire logic irq_od = ctrl_q[seq_pkg::CTRL_OD_BIT];
    logic [31:0] rd_mux;

    // read data selection
    always_comb begin
        rd_mux = '0;
        if (reg_addr == seq_pkg::REG_CTRL) rd_mux = ctrl_q;
        else if (reg_addr == seq_pkg::REG_STATUS) rd_mux = 32'(status_q);
        else if (reg_addr == seq_pkg::REG_MASK) rd_mux = mask_q;
        else if (reg_addr == seq_pkg::REG_STATE)
            rd_mux = {26'h0, ld_done_q, bias_on, buck_run};
        else if (reg_addr[3:2] == seq_pkg::REG_CFG0[3:2])
            rd_mux = cfg_q[reg_addr[1:0]];
        else if (reg_addr[3:2] == seq_pkg::REG_VTGT0[3:2])
            rd_mux = {22'h0, vtgt_q[reg_addr[1:0]]};
    end

    // -----------------------------------------------------------------
    // timebase
    // -----------------------------------------------------------------
    // microsecond and millisecond enable pulses
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            us_cnt_q <= '0;
            ms_cnt_q <= '0;
            us_tick_q <= 1'b0;
            ms_tick_q <= 1'b0;
        end else begin
            us_tick_q <= (us_cnt_q == 6'(seq_pkg::US_CYC - 1));
            us_cnt_q <= (us_cnt_q == 6'(seq_pkg::US_CYC - 1)) ? 6'h00 :
                us_cnt_q + 6'h01; // wrap at the last count, not one later
            ms_tick_q <= us_tick_q && (ms_cnt_q == 10'(seq_pkg::MS_US - 1));
            if (ms_tick_q) ms_cnt_q <= 10'h000;
            else if (us_tick_q) ms_cnt_q <= ms_cnt_q + 10'h001;
        end
    end

    // -----------------------------------------------------------------
    // chip sequence and boot load
    // -----------------------------------------------------------------
    assign otp.addr = ld_a_q;
    assign otp.rd = (gst_q == seq_pkg::G_BOOT) && !ld_done_q;

    otp_store u_otp (
        .ref_clk(ref_clk),
        .port(otp.store)
    );

    // boot, run and shutdown of the whole chip
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gst_q <= seq_pkg::G_OFF;
            boot_cnt_q <= '0;
            ld_a_q <= '0;
            ld_vld_q <= 1'b0;
            ld_done_q <= 1'b0;
        end else begin
            ld_vld_q <= otp.rd;
            if (otp.rd && ld_a_q != seq_pkg::OTP_LAST) ld_a_q <= ld_a_q + 3'h1;
            if (otp.rd && ld_a_q == seq_pkg::OTP_LAST) ld_done_q <= 1'b1;
            if (boot_cnt_q != 17'h0_0000) boot_cnt_q <= boot_cnt_q - 17'h0_0001;
            unique case (gst_q)
                seq_pkg::G_OFF: if (chip_en) begin
                    gst_q <= seq_pkg::G_BOOT;
                    boot_cnt_q <= 17'(BOOT_CYC - 1);
                    ld_a_q <= '0;
                    ld_done_q <= 1'b0;
                end
                seq_pkg::G_BOOT: if (!chip_en) gst_q <= seq_pkg::G_OFF;
                    else if (boot_done) gst_q <= seq_pkg::G_RUN;
                seq_pkg::G_RUN: if (!chip_en) gst_q <= seq_pkg::G_STOP;
                seq_pkg::G_STOP: if (&is_off) gst_q <= seq_pkg::G_OFF;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    // boot image, bus writes and watchdog restore
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q <= '0;
            mask_q <= '0;
            status_q <= '0;
            for (int k = 0; k < 4; k++) begin
                cfg_q[k] <= '0;
                vtgt_q[k] <= '0;
            end
        end else begin
            status_q <= (status_q & ~st_clr) | st_ev; // set wins over clear
            if (ld_vld_q && ld_a_q == 3'h1) ctrl_q <= otp.data;
            if (ld_vld_q && ld_a_q != 3'h1 && !ld_done_q) begin
                cfg_q[2'(ld_a_q - 3'h2)] <= otp.data;
                vtgt_q[2'(ld_a_q - 3'h2)] <=
                    otp.data[seq_pkg::CFG_DEF_LSB +: 10];
            end
            if (ld_done_q && ld_a_q == seq_pkg::OTP_LAST && ld_vld_q) begin
                cfg_q[3] <= otp.data;
                vtgt_q[3] <= otp.data[seq_pkg::CFG_DEF_LSB +: 10];
            end
            if (reg_wr && reg_addr == seq_pkg::REG_CTRL) ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == seq_pkg::REG_MASK) mask_q <= reg_wdata;
            if (reg_wr && reg_addr[3:2] == seq_pkg::REG_CFG0[3:2])
                cfg_q[reg_addr[1:0]] <= reg_wdata;
            if (reg_wr && reg_addr[3:2] == seq_pkg::REG_VTGT0[3:2])
                vtgt_q[reg_addr[1:0]] <= reg_wdata[9:0];
            if (wd_fire) begin
                for (int k = 0; k < 4; k++)
                    vtgt_q[k] <= cfg_q[k][seq_pkg::CFG_DEF_LSB +: 10];
            end
        end
    end

    // host-alive low-time counter, fires once per low period
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !wd_low) wd_cnt_q <= '0;
        else if (wd_cnt_q != 19'(WDOG_CYC)) wd_cnt_q <= wd_cnt_q + 19'h0_0001;
    end

    // -----------------------------------------------------------------
    // per-buck sequencer
    // -----------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_buck
        wire logic go_down = (st_q[i] == seq_pkg::B_RAMP_DN) ||
            (vo_q[i] > vtgt_q[i]);
        wire logic [2:0] rate = go_down ?
            fld3(cfg_q[i], seq_pkg::CFG_DN_LSB) :
            fld3(cfg_q[i], seq_pkg::CFG_UP_LSB);
        assign step[i] = us_tick_q && (slc_q[i] == rate);
        assign is_off[i] = (st_q[i] == seq_pkg::B_OFF);

        // state, delay counter and output code of one buck
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                st_q[i] <= seq_pkg::B_OFF;
                cnt_q[i] <= '0;
                vo_q[i] <= '0;
                slc_q[i] <= '0;
                pd_q[i] <= 1'b0;
                first_q[i] <= 1'b0;
                cause_q[i] <= 1'b0;
            end else begin
                if (step[i]) slc_q[i] <= 3'h0;
                else if (us_tick_q) slc_q[i] <= slc_q[i] + 3'h1;
                if (gst_q == seq_pkg::G_BOOT && boot_done)
                    first_q[i] <= auto_mode;
                unique case (st_q[i])
                    seq_pkg::B_OFF: if (want[i] && !ot_fault) begin
                        pd_q[i] <= 1'b0;
                        if (first_q[i] && auto_mode) begin
                            st_q[i] <= seq_pkg::B_DLY_ON;
                            cnt_q[i] <= {5'h00,
                                fld6(cfg_q[i], seq_pkg::CFG_START_LSB)};
                        end else st_q[i] <= seq_pkg::B_RAMP;
                    end
                    seq_pkg::B_DLY_ON: if (!want[i]) st_q[i] <= seq_pkg::B_OFF;
                        else if (cnt_q[i] == 11'h000 || !auto_mode) begin
                            st_q[i] <= seq_pkg::B_RAMP;
                            first_q[i] <= 1'b0;
                        end else if (ms_tick_q) cnt_q[i] <= cnt_q[i] - 11'h001;
                    seq_pkg::B_RAMP: if (ot_fault || oc_fault[i] || uv_fault[i]) begin
                        st_q[i] <= seq_pkg::B_HOLD;
                        cnt_q[i] <= seq_pkg::RETRY_MS;
                        vo_q[i] <= '0;
                    end else if (ov_fault[i]) begin
                        st_q[i] <= seq_pkg::B_CROWBAR;
                        cnt_q[i] <= seq_pkg::CROWBAR_CYC;
                        vo_q[i] <= '0;
                    end else if (!want[i] && stopping) begin
                        st_q[i] <= seq_pkg::B_DLY_OFF;
                        cnt_q[i] <= {5'h00,
                            fld6(cfg_q[i], seq_pkg::CFG_STOP_LSB)};
                    end else if (!want[i]) begin
                        st_q[i] <= seq_pkg::B_RAMP_DN;
                        cause_q[i] <= 1'b0;
                    end else if (step[i] && vo_q[i] < vtgt_q[i])
                        vo_q[i] <= vo_q[i] + 10'h001;
                    else if (step[i] && go_down) vo_q[i] <= vo_q[i] - 10'h001;
                    seq_pkg::B_DLY_OFF: if (cnt_q[i] == 11'h000) begin
                        st_q[i] <= seq_pkg::B_RAMP_DN;
                        cause_q[i] <= 1'b1;
                    end else if (ms_tick_q) cnt_q[i] <= cnt_q[i] - 11'h001;
                    seq_pkg::B_RAMP_DN: if (vo_q[i] <= seq_pkg::FLOOR_CODE) begin
                        st_q[i] <= seq_pkg::B_OFF;
                        vo_q[i] <= '0;
                        pd_q[i] <= !cause_q[i] && dis_sel[i];
                    end else if (step[i]) vo_q[i] <= vo_q[i] - 10'h001;
                    seq_pkg::B_CROWBAR: if (cnt_q[i] == 11'h000) begin
                        st_q[i] <= seq_pkg::B_HOLD;
                        cnt_q[i] <= seq_pkg::RETRY_MS;
                    end else cnt_q[i] <= cnt_q[i] - 11'h001;
                    seq_pkg::B_HOLD: if (stopping) st_q[i] <= seq_pkg::B_OFF;
                        else if (cnt_q[i] == 11'h000 && !ot_fault)
                            st_q[i] <= seq_pkg::B_OFF;
                        else if (ms_tick_q && cnt_q[i] != 11'h000)
                            cnt_q[i] <= cnt_q[i] - 11'h001;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
            bias_on <= 1'b0;
            buck_run <= '0;
            stage_hiz <= '0;
            low_side_on <= '0;
            weak_pd_on <= '0;
            vout_code <= '0;
            ovuv_window <= '0;
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
            bias_on <= (gst_q != seq_pkg::G_OFF);
            ovuv_window <= ctrl_q[seq_pkg::CTRL_WIN_LSB +: 2];
            irq_out <= irq_od ? 1'b0 : irq_lvl;
            irq_oe <= irq_od ? !irq_lvl : 1'b1;
            for (int k = 0; k < 4; k++) begin
                buck_run[k] <= (st_q[k] == seq_pkg::B_RAMP) ||
                    (st_q[k] == seq_pkg::B_RAMP_DN);
                stage_hiz[k] <= (st_q[k] == seq_pkg::B_HOLD);
                low_side_on[k] <= (st_q[k] == seq_pkg::B_CROWBAR);
                weak_pd_on[k] <= pd_q[k];
                vout_code[k*10 +: 10] <= vo_q[k];
            end
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_boot;
        (gst_q == seq_pkg::G_BOOT && chip_en && boot_done) |=>
            (gst_q == seq_pkg::G_RUN) ##1 bias_on;
    endproperty
    a_boot: assert property (p_boot) else $error("boot not finished");
    property p_manual;
        (st_q[0] == seq_pkg::B_OFF && want[0] && !ot_fault && !first_q[0])
            |=> st_q[0] == seq_pkg::B_RAMP ##1 buck_run[0];
    endproperty
    a_manual: assert property (p_manual) else $error("late start");
    property p_delay;
        (st_q[0] == seq_pkg::B_DLY_ON && want[0] && cnt_q[0] != 11'h000 &&
            auto_mode && !ms_tick_q) |=>
            st_q[0] == seq_pkg::B_DLY_ON && $stable(cnt_q[0]);
    endproperty
    a_delay: assert property (p_delay) else $error("delay slipped");
    property p_mdown;
        (st_q[0] == seq_pkg::B_RAMP && !want[0] && running &&
            !ot_fault && !oc_fault[0] && !uv_fault[0] && !ov_fault[0])
            |=> st_q[0] == seq_pkg::B_RAMP_DN;
    endproperty
    a_mdown: assert property (p_mdown) else $error("no ramp down");
    property p_cdown;
        (st_q[0] == seq_pkg::B_RAMP && stopping && !ot_fault &&
            !oc_fault[0] && !uv_fault[0] && !ov_fault[0])
            |=> st_q[0] == seq_pkg::B_DLY_OFF;
    endproperty
    a_cdown: assert property (p_cdown) else $error("no stop delay");
    property p_nopd;
        (st_q[0] == seq_pkg::B_RAMP_DN && cause_q[0] &&
            vo_q[0] <= seq_pkg::FLOOR_CODE) |=> ##1 !weak_pd_on[0];
    endproperty
    a_nopd: assert property (p_nopd) else $error("pull-down on");
    property p_wdog;
        wd_fire |=> vtgt_q[1] == cfg_q[1][seq_pkg::CFG_DEF_LSB +: 10];
    endproperty
    a_wdog: assert property (p_wdog) else $error("no restore");
    property p_ot;
        (ot_fault && st_q[2] == seq_pkg::B_RAMP) |=>
            st_q[2] == seq_pkg::B_HOLD ##1 !buck_run[2];
    endproperty
    a_ot: assert property (p_ot) else $error("ot not obeyed");
    property p_crowbar;
        $rose(st_q[0] == seq_pkg::B_CROWBAR) |->
            (st_q[0] == seq_pkg::B_CROWBAR)[*8] ##1 low_side_on[0];
    endproperty
    a_crowbar: assert property (p_crowbar) else $error("crowbar");
    property p_irq;
        (irq_act && !irq_od && ctrl_q[seq_pkg::CTRL_POL_BIT] &&
            $stable(ctrl_q)) |=> irq_out && irq_oe;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not driven");

    c_auto: cover property (st_q[3] == seq_pkg::B_DLY_ON ##1
        st_q[3] == seq_pkg::B_RAMP);
    c_shut: cover property (stopping ##1 gst_q == seq_pkg::G_OFF);
    c_wdog: cover property (wd_fire);
    c_retry: cover property (st_q[1] == seq_pkg::B_HOLD ##1
        st_q[1] == seq_pkg::B_OFF);
endmodule : buck_sequencer

// >>> core/otp_store.sv
// one-time configuration memory with registered read data
`timescale 1ns/10ps
module otp_store (
    input wire logic ref_clk,
    otp_if.store port
);
    // -----------------------------------------------------------------
    // fixed image
    // -----------------------------------------------------------------
    function automatic logic [31:0] image(input logic [2:0] a);
        image = (a == 3'h0) ? seq_pkg::OTP_CTRL_DEF : seq_pkg::OTP_CFG_DEF;
    endfunction : image

    // read data leave from a register
    always_ff @(posedge ref_clk) begin
        if (port.rd) begin
            port.data <= image(port.addr);
        end
    end
endmodule : otp_store

// >>> shared/otp_if.sv
// read port between the boot loader and the one-time memory
`timescale 1ns/10ps
interface otp_if;
    logic [2:0] addr;
    logic rd;
    logic [31:0] data;
    modport reader(output addr, output rd, input data);
    modport store(input addr, input rd, output data);
endinterface : otp_if

// >>> shared/seq_pkg.sv
// constants, register map and state types of the buck sequencer
package seq_pkg;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int US_CYC = CLK_HZ / 1_000_000; // cycles per microsecond
    localparam int MS_US = 1000;
    localparam int BOOT_US = 1400; // boot interval in us
    localparam int BOOT_CYC = BOOT_US * US_CYC;
    localparam int WDOG_MS = 10; // host-alive debounce in ms
    localparam int WDOG_CYC = WDOG_MS * MS_US * US_CYC;
    localparam int CROWBAR_US = 32; // shortest crowbar time in us
    localparam logic [10:0] CROWBAR_CYC = 11'(CROWBAR_US * US_CYC - 1);
    localparam logic [10:0] RETRY_MS = 11'h004; // fault retry period, ms
    localparam logic [9:0] FLOOR_CODE = 10'h0a6; // about 250mV
    localparam logic [2:0] PIN_FN_EN = 3'h1; // enable pins active
    // -----------------------------------------------------------------
    // register map, word addresses
    // -----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_STATE = 4'h3;
    localparam logic [3:0] REG_CFG0 = 4'h4; // 4..7 per buck
    localparam logic [3:0] REG_VTGT0 = 4'h8; // 8..11 per buck
    // control fields
    localparam int CTRL_ON_LSB = 0;
    localparam int CTRL_PIN_LSB = 4;
    localparam int CTRL_AUTO_BIT = 7;
    localparam int CTRL_DIS_LSB = 8;
    localparam int CTRL_WIN_LSB = 12;
    localparam int CTRL_POL_BIT = 14;
    localparam int CTRL_OD_BIT = 15;
    // per-buck config fields
    localparam int CFG_START_LSB = 0;
    localparam int CFG_STOP_LSB = 6;
    localparam int CFG_UP_LSB = 12;
    localparam int CFG_DN_LSB = 15;
    localparam int CFG_DEF_LSB = 18;
    // status fields
    localparam int ST_W = 14;
    localparam int ST_WD_BIT = 13;
    // -----------------------------------------------------------------
    // one-time memory image
    // -----------------------------------------------------------------
    localparam logic [2:0] OTP_LAST = 3'h4;
    localparam logic [31:0] OTP_CTRL_DEF = 32'h0000_008f;
    localparam logic [31:0] OTP_CFG_DEF = 32'h0801_2041;
    // -----------------------------------------------------------------
    // states
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        G_OFF = 4'b0001, G_BOOT = 4'b0010, G_RUN = 4'b0100, G_STOP = 4'b1000
    } chip_st_t;
    typedef enum logic [6:0] {
        B_OFF = 7'b000_0001, B_DLY_ON = 7'b000_0010, B_RAMP = 7'b000_0100,
        B_DLY_OFF = 7'b000_1000, B_RAMP_DN = 7'b001_0000,
        B_CROWBAR = 7'b010_0000, B_HOLD = 7'b100_0000
    } buck_st_t;
endpackage : seq_pkg
